// ===== inc/nid_pkg.sv
// Package for the node identity and physical-layer register access block
package nid_pkg;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam int NID_ADDR_W = 12;
    localparam logic [11:0] NID_OFS_NODE_IDENTITY = 12'h0e8;
    localparam logic [11:0] NID_OFS_PHY_ACCESS = 12'h0ec;
    localparam logic [11:0] NID_OFS_IRQ_STATUS = 12'h0f4;
    localparam logic [11:0] NID_OFS_IRQ_MASK = 12'h0f8;

    // ----------------------------------------------------------------
    // Node identity field positions
    // ----------------------------------------------------------------
    localparam int NID_ID_VALID_BIT = 31;
    localparam int NID_ROOT_BIT = 30;
    localparam int NID_CABLE_POWER_BIT = 27;
    localparam int NID_BUS_INDEX_LSB = 6;
    localparam int NID_NODE_INDEX_LSB = 0;
    localparam logic [9:0] NID_BUS_INDEX_RST = 10'h3ff;
    localparam logic [5:0] NID_NODE_INDEX_RST = 6'h00;

    // ----------------------------------------------------------------
    // Physical-layer access field positions
    // ----------------------------------------------------------------
    localparam int NID_RD_COMPLETE_BIT = 31;
    localparam int NID_RD_ADDRESS_LSB = 24;
    localparam int NID_RD_VALUE_LSB = 16;
    localparam int NID_RD_REQUEST_BIT = 15;
    localparam int NID_WR_REQUEST_BIT = 14;
    localparam int NID_TARGET_ADDR_LSB = 8;
    localparam int NID_WRITE_VALUE_LSB = 0;
    localparam logic [3:0] NID_TARGET_ADDR_RST = 4'h0;
    localparam logic [7:0] NID_WRITE_VALUE_RST = 8'h00;

    // ----------------------------------------------------------------
    // Interrupt status and mask bits
    // ----------------------------------------------------------------
    localparam int NID_IRQ_W = 4;
    localparam int NID_IRQ_BUS_RESET = 0;
    localparam int NID_IRQ_ID_VALID = 1;
    localparam int NID_IRQ_RD_COMPLETE = 2;
    localparam int NID_IRQ_REQ_SENT = 3;
    localparam logic [3:0] NID_IRQ_MASK_RST = 4'h0;

    // Status reported by the physical-layer side of the link
    typedef struct packed {
        logic bus_reset;
        logic self_id_done;
        logic [5:0] node_number;
        logic is_root;
        logic cable_power;
    } nid_phy_status_t;

    // Register transfer request toward the physical layer
    typedef struct packed {
        logic valid;
        logic is_write;
        logic [3:0] addr;
        logic [7:0] data;
    } nid_phy_req_t;

    // Register transfer received from the physical layer
    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic [7:0] data;
    } nid_phy_rx_t;

endpackage

// ===== hw/nid_regs.sv
// Node identity and physical-layer register access, AHB-Lite slave
//
// Decided for this implementation: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Node identifier is bus index in bits 15-6 over node index in 5-0.
// - Valid flag clears on bus reset, sets when new node number arrives.
// - Root flag set during bus reset processing when physical layer is root.
// - Cable power bit follows the physical layer's cable power report.
// - Node identity bits 29-28 and 26-16 read as zero.
// - Bus index is software writable, hardware updatable, resets to all ones.
// - Node index loads from physical layer after self-identification; not writable.
// - Read complete clears when software sets either request bit.
// - Read complete sets when a register transfer arrives.
// - Read address captures the address of the latest received transfer.
// - Read value captures the returned register contents.
// - Software sets read request; hardware clears it once sent.
// - Software sets write request; hardware clears it once sent.
// - Target address is used for reads and writes; read/write, resets zero.
// - Write value is sent for writes, ignored for reads, resets zero.
// - Access register bits 30-28 and 13-12 read as zero.
module nid_regs
    import nid_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [NID_ADDR_W-1:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire nid_phy_status_t phy_status,
    input wire logic hw_bus_index_load,
    input wire logic [9:0] hw_bus_index,
    output nid_phy_req_t phy_req,
    input wire logic phy_req_ready,
    input wire nid_phy_rx_t phy_rx,
    output logic [15:0] node_id,
    output logic irq
);

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic node_id_valid;
    logic root;
    logic cable_power_ok;
    logic [9:0] bus_index;
    logic [5:0] physical_node_index;
    logic phy_read_complete;
    logic [3:0] phy_read_address;
    logic [7:0] phy_read_value;
    logic phy_read_request;
    logic phy_write_request;
    logic [3:0] phy_target_address;
    logic [7:0] phy_write_value;
    logic [NID_IRQ_W-1:0] irq_status;
    logic [NID_IRQ_W-1:0] irq_mask;

    // ----------------------------------------------------------------
    // AHB-Lite address and data phase
    // ----------------------------------------------------------------
    logic dp_write;
    logic dp_read;
    logic [NID_ADDR_W-1:0] dp_addr;
    logic addr_take;
    logic wr_node;
    logic wr_phy;
    logic wr_irq_status;
    logic wr_irq_mask;
    logic req_sent;
    logic [31:0] next_rdata;
    logic [NID_IRQ_W-1:0] irq_event;

    // Only single word transfers are expected; hsize is not decoded
    assign addr_take = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // Latch the address phase so the write lands in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= '0;
        end else begin
            dp_write <= addr_take && hwrite;
            dp_read <= addr_take && !hwrite;
            dp_addr <= addr_take ? haddr : dp_addr;
        end
    end

    assign wr_node = dp_write && (dp_addr == NID_OFS_NODE_IDENTITY);
    assign wr_phy = dp_write && (dp_addr == NID_OFS_PHY_ACCESS);
    assign wr_irq_status = dp_write && (dp_addr == NID_OFS_IRQ_STATUS);
    assign wr_irq_mask = dp_write && (dp_addr == NID_OFS_IRQ_MASK);

    // Read mux; unmapped addresses read zero
    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (haddr)
            NID_OFS_NODE_IDENTITY: begin
                next_rdata[NID_ID_VALID_BIT] = node_id_valid;
                next_rdata[NID_ROOT_BIT] = root;
                next_rdata[NID_CABLE_POWER_BIT] = cable_power_ok;
                next_rdata[15:0] = node_id;
            end
            NID_OFS_PHY_ACCESS: begin
                next_rdata[NID_RD_COMPLETE_BIT] = phy_read_complete;
                next_rdata[NID_RD_ADDRESS_LSB +: 4] = phy_read_address;
                next_rdata[NID_RD_VALUE_LSB +: 8] = phy_read_value;
                next_rdata[NID_RD_REQUEST_BIT] = phy_read_request;
                next_rdata[NID_WR_REQUEST_BIT] = phy_write_request;
                next_rdata[NID_TARGET_ADDR_LSB +: 4] = phy_target_address;
                next_rdata[NID_WRITE_VALUE_LSB +: 8] = phy_write_value;
            end
            NID_OFS_IRQ_STATUS: next_rdata[NID_IRQ_W-1:0] = irq_status;
            NID_OFS_IRQ_MASK: next_rdata[NID_IRQ_W-1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    // Read data is sampled at the address phase, so it stands from a flop
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (addr_take && !hwrite) begin
            hrdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // Node identity
    // ----------------------------------------------------------------
    // node identifier
    assign node_id = {bus_index, physical_node_index};

    // valid flag; a bus reset beats a coincident node number
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            node_id_valid <= 1'b0;
        end else if (phy_status.bus_reset) begin
            node_id_valid <= 1'b0;
        end else if (phy_status.self_id_done) begin
            node_id_valid <= 1'b1;
        end
    end

    // root flag taken from the physical layer during reset processing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            root <= 1'b0;
        end else if (phy_status.bus_reset || phy_status.self_id_done) begin
            root <= phy_status.is_root;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cable_power_ok <= 1'b0;
        end else begin
            cable_power_ok <= phy_status.cable_power;
        end
    end

    // bus index: hardware update wins over a coincident software write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_index <= NID_BUS_INDEX_RST;
        end else if (hw_bus_index_load) begin
            bus_index <= hw_bus_index;
        end else if (wr_node) begin
            bus_index <= hwdata[NID_BUS_INDEX_LSB +: 10];
        end
    end

    // node index loads only from the physical layer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            physical_node_index <= NID_NODE_INDEX_RST;
        end else if (phy_status.self_id_done && !phy_status.bus_reset) begin
            physical_node_index <= phy_status.node_number;
        end
    end

    // ----------------------------------------------------------------
    // Physical-layer register access
    // ----------------------------------------------------------------
    // target address and write value, plain read/write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_target_address <= NID_TARGET_ADDR_RST;
            phy_write_value <= NID_WRITE_VALUE_RST;
        end else if (wr_phy) begin
            phy_target_address <= hwdata[NID_TARGET_ADDR_LSB +: 4];
            phy_write_value <= hwdata[NID_WRITE_VALUE_LSB +: 8];
        end
    end

    // request bits: a new software set beats the sent clear.
    // Writing zero does not cancel a pending request, since it may already
    // be on its way to the physical layer.
    assign req_sent = phy_req.valid && phy_req_ready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_read_request <= 1'b0;
            phy_write_request <= 1'b0;
        end else if (wr_phy && (hwdata[NID_RD_REQUEST_BIT] || hwdata[NID_WR_REQUEST_BIT])) begin
            phy_read_request <= hwdata[NID_RD_REQUEST_BIT];
            phy_write_request <= hwdata[NID_WR_REQUEST_BIT];
        end else if (req_sent) begin
            phy_read_request <= 1'b0;
            phy_write_request <= 1'b0;
        end
    end

    // both set is illegal; a read is issued if it happens anyway
    // request drives target address and write value
    // One driver for the whole struct: valid, is_write, addr, data
    assign phy_req = {
        phy_read_request || phy_write_request,
        phy_write_request && !phy_read_request,
        phy_target_address,
        phy_write_value
    };

    // completion and captured data set together on each arrival
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_read_address <= 4'h0;
            phy_read_value <= 8'h00;
        end else if (phy_rx.valid) begin
            phy_read_address <= phy_rx.addr;
            phy_read_value <= phy_rx.data;
        end
    end

    // set on arrival, clear on a new request; arrival wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            phy_read_complete <= 1'b0;
        end else if (phy_rx.valid) begin
            phy_read_complete <= 1'b1;
        end else if (wr_phy && (hwdata[NID_RD_REQUEST_BIT] || hwdata[NID_WR_REQUEST_BIT])) begin
            phy_read_complete <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupts
    // ----------------------------------------------------------------
    assign irq_event[NID_IRQ_BUS_RESET] = phy_status.bus_reset;
    assign irq_event[NID_IRQ_ID_VALID] = phy_status.self_id_done && !phy_status.bus_reset;
    assign irq_event[NID_IRQ_RD_COMPLETE] = phy_rx.valid;
    assign irq_event[NID_IRQ_REQ_SENT] = req_sent;

    // Sticky status, write one to clear; a fresh event beats the clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_status <= '0;
        end else begin
            irq_status <= irq_event | (irq_status & ~(wr_irq_status ? hwdata[NID_IRQ_W-1:0] : '0));
        end
    end

    // Mask register, one enables the bit onto irq
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask <= NID_IRQ_MASK_RST;
        end else if (wr_irq_mask) begin
            irq_mask <= hwdata[NID_IRQ_W-1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic sw_req_set;
    assign sw_req_set = wr_phy && (hwdata[NID_RD_REQUEST_BIT] || hwdata[NID_WR_REQUEST_BIT]);

    // node identity read shows the id
    a_node_id_read: assert property (dp_read && dp_addr == NID_OFS_NODE_IDENTITY && $past(!wr_node && !hw_bus_index_load && !phy_status.self_id_done) |-> hrdata[15:0] == node_id)
        else $error("node id read mismatch");
    // valid cleared by bus reset, set by new number
    a_valid_flag: assert property (phy_status.bus_reset |=> !node_id_valid)
        else $error("valid flag not cleared");
    a_valid_set: assert property (phy_status.self_id_done && !phy_status.bus_reset |=> node_id_valid && physical_node_index == $past(phy_status.node_number))
        else $error("node number not loaded");
    // root follows the report on reset processing
    a_root_load: assert property (phy_status.bus_reset |=> root == $past(phy_status.is_root))
        else $error("root flag wrong");
    // cable power tracks within one cycle
    a_cable_power: assert property (##1 cable_power_ok == $past(phy_status.cable_power))
        else $error("cable power stale");
    a_rsvd_node: assert property (dp_read && dp_addr == NID_OFS_NODE_IDENTITY |-> hrdata[29:28] == 2'h0 && hrdata[26:16] == 11'h000)
        else $error("node identity reserved bits set");
    a_rsvd_phy: assert property (dp_read && dp_addr == NID_OFS_PHY_ACCESS |-> hrdata[30:28] == 3'h0 && hrdata[13:12] == 2'h0)
        else $error("access reserved bits set");
    // software write leaves node index alone
    a_index_locked: assert property (wr_node && !phy_status.self_id_done |=> $stable(physical_node_index))
        else $error("node index written by software");
    a_complete_clear: assert property (sw_req_set && !phy_rx.valid |=> !phy_read_complete)
        else $error("completion not cleared");
    a_capture_rx: assert property (phy_rx.valid |=> phy_read_complete && phy_read_address == $past(phy_rx.addr) && phy_read_value == $past(phy_rx.data))
        else $error("transfer capture incomplete");
    a_req_clear: assert property (req_sent && !sw_req_set |=> !phy_read_request && !phy_write_request)
        else $error("request bit not cleared");
    a_req_fields: assert property (phy_req.valid |-> phy_req.addr == phy_target_address && phy_req.data == phy_write_value && phy_req.is_write == !phy_read_request)
        else $error("request fields wrong");
    a_bus_index_wr: assert property (wr_node && !hw_bus_index_load |=> bus_index == $past(hwdata[15:6]))
        else $error("bus index not written");
    // Mask write in the arrival cycle would change the mask seen next cycle
    a_irq_level: assert property (phy_rx.valid && irq_mask[NID_IRQ_RD_COMPLETE] && !wr_irq_mask |=> irq)
        else $error("interrupt not raised");

    c_phy_read: cover property (phy_read_request && req_sent ##[1:50] phy_rx.valid);
    c_phy_write: cover property (phy_write_request && req_sent);
    c_reset_to_valid: cover property (phy_status.bus_reset ##[1:100] node_id_valid);
    c_irq_clear: cover property (irq ##[1:20] !irq);

endmodule

`default_nettype wire

// ===== tb/nid_phy_model.sv
// Behavioural physical-layer partner that answers register transfers
`timescale 1ns/100ps
`default_nettype none
module nid_phy_model
    import nid_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire nid_phy_req_t phy_req,
    input wire logic [3:0] stall,
    output logic phy_req_ready,
    output nid_phy_rx_t phy_rx
);
    logic [7:0] regs [16];
    logic [3:0] wait_cnt;
    logic [1:0] pend;
    logic [3:0] pend_addr;

    // ----------------------------------------------------------------
    // Acceptance
    // ----------------------------------------------------------------
    // Stall lets the bench see a request while it is still pending
    assign phy_req_ready = phy_req.valid && (wait_cnt >= stall);

    // ----------------------------------------------------------------
    // Register file and read answers
    // ----------------------------------------------------------------
    // Idle rx lines flip every cycle so stale data never looks valid
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt <= 4'h0;
            pend <= 2'h0;
            pend_addr <= 4'h0;
            phy_rx <= '0;
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 8'h00;
            end
        end else begin
            wait_cnt <= (phy_req.valid && !phy_req_ready) ? wait_cnt + 4'h1 : 4'h0;
            phy_rx.valid <= 1'b0;
            phy_rx.addr <= ~phy_rx.addr;
            phy_rx.data <= ~phy_rx.data;
            if (pend != 2'h0) begin
                pend <= pend - 2'h1;
            end
            if (pend == 2'h1) begin
                phy_rx.valid <= 1'b1;
                phy_rx.addr <= pend_addr;
                phy_rx.data <= regs[pend_addr];
            end
            if (phy_req_ready && phy_req.is_write) begin
                regs[phy_req.addr] <= phy_req.data;
            end
            if (phy_req_ready && !phy_req.is_write) begin
                pend <= 2'h2;
                pend_addr <= phy_req.addr;
            end
        end
    end
endmodule
`default_nettype wire

// ===== tb/nid_regs_tb.sv
// Self-checking bench for the node identity and register access block
`timescale 1ns/100ps
`default_nettype none
module nid_regs_tb
    import nid_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, hw_bus_index_load, phy_req_ready;
    logic [11:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, rd;
    logic [9:0] hw_bus_index;
    logic [15:0] node_id;
    logic [3:0] stall;
    nid_phy_status_t st;
    nid_phy_req_t phy_req;
    nid_phy_rx_t phy_rx;
    int fail_count, checks;

    assign hready = hreadyout;

    nid_regs nid_regs_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .phy_status(st), .hw_bus_index_load(hw_bus_index_load),
        .hw_bus_index(hw_bus_index), .phy_req(phy_req), .phy_req_ready(phy_req_ready),
        .phy_rx(phy_rx), .node_id(node_id), .irq(irq));

    nid_phy_model nid_phy_model_inst (.hclk(hclk), .hresetn(hresetn), .phy_req(phy_req), .stall(stall),
        .phy_req_ready(phy_req_ready), .phy_rx(phy_rx));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One single transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do begin @(posedge hclk); n++; end while (hready !== 1'b1 && n < 50);
        rd = hrdata;
        if (n >= 50) begin
            fail_count++;
            results();
        end
    endtask

    task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        check(what, rd, exp);
    endtask

    // Bounded poll until the masked bits reach the wanted value
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin ahb(1'b0, a, 32'h0); n++; end while ((rd & m) !== e && n < 40);
        if (n >= 40) begin
            fail_count++;
            results();
        end
    endtask

    task automatic pulse_status(input logic rst_ev, input logic [5:0] num, input logic root);
        st.bus_reset <= rst_ev;
        st.self_id_done <= !rst_ev;
        st.node_number <= num;
        st.is_root <= root;
        @(posedge hclk);
        st.bus_reset <= 1'b0;
        st.self_id_done <= 1'b0;
        @(posedge hclk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        rdchk("id_reset", NID_OFS_NODE_IDENTITY, 32'h0000ffc0);
        rdchk("acc_reset", NID_OFS_PHY_ACCESS, 32'h00000000);
        rdchk("unmapped", 12'h0f0, 32'h00000000);
        ahb(1'b1, NID_OFS_PHY_ACCESS, 32'h70003f12);
        rdchk("acc_rsvd", NID_OFS_PHY_ACCESS, 32'h00000f12);
        ahb(1'b1, NID_OFS_PHY_ACCESS, 32'h00000000);
        // only the bus index is writable
        ahb(1'b1, NID_OFS_NODE_IDENTITY, 32'hffffffff);
        rdchk("id_rsvd", NID_OFS_NODE_IDENTITY, 32'h0000ffc0);
        $display("test reset done");
    endtask

    task automatic t_node();
        st.cable_power <= 1'b1;
        pulse_status(1'b1, 6'h00, 1'b1);
        rdchk("bus_reset", NID_OFS_NODE_IDENTITY, 32'h4800ffc0);
        pulse_status(1'b0, 6'h05, 1'b0);
        rdchk("self_id", NID_OFS_NODE_IDENTITY, 32'h8800ffc5);
        ahb(1'b1, NID_OFS_NODE_IDENTITY, 32'h00000000);
        rdchk("bus_wr", NID_OFS_NODE_IDENTITY, 32'h88000005);
        hw_bus_index <= 10'h155;
        hw_bus_index_load <= 1'b1;
        @(posedge hclk);
        hw_bus_index_load <= 1'b0;
        @(posedge hclk);
        check("node_id", {16'h0, node_id}, 32'h00005545);
        st.cable_power <= 1'b0;
        pulse_status(1'b1, 6'h00, 1'b0);
        rdchk("reset_again", NID_OFS_NODE_IDENTITY, 32'h00005545);
        // node index 63: this bench never starts a transmit context
        pulse_status(1'b0, 6'h3f, 1'b1);
        check("node_63", {16'h0, node_id}, 32'h0000557f);
        $display("test node done");
    endtask

    task automatic t_phy();
        // every request write below sets exactly one request bit
        stall <= 4'h6;
        ahb(1'b1, NID_OFS_PHY_ACCESS, 32'h00004a3c);
        rdchk("wr_pending", NID_OFS_PHY_ACCESS, 32'h00004a3c);
        check("req_fields", {18'h0, phy_req}, 32'h00003a3c);
        poll(NID_OFS_PHY_ACCESS, 32'h00004000, 32'h0);
        ahb(1'b1, NID_OFS_PHY_ACCESS, 32'h00008a77);
        poll(NID_OFS_PHY_ACCESS, 32'h80000000, 32'h80000000);
        // captured address, request bit already cleared
        check("rd_done", rd, 32'h8a3c0a77);
        // a new request drops completion but keeps captured data
        ahb(1'b1, NID_OFS_PHY_ACCESS, 32'h00004a3c);
        rdchk("done_clr", NID_OFS_PHY_ACCESS, 32'h0a3c4a3c);
        poll(NID_OFS_PHY_ACCESS, 32'h00004000, 32'h0);
        stall <= 4'h0;
        $display("test phy done");
    endtask

    task automatic t_irq();
        rdchk("status", NID_OFS_IRQ_STATUS, 32'h0000000f);
        check("irq_masked", {31'h0, irq}, 32'h0);
        ahb(1'b1, NID_OFS_IRQ_MASK, 32'h00000004);
        // The mask lands on the edge the write returns at, so read it back first
        rdchk("mask", NID_OFS_IRQ_MASK, 32'h00000004);
        check("irq_on", {31'h0, irq}, 32'h1);
        ahb(1'b1, NID_OFS_IRQ_STATUS, 32'h00000004);
        rdchk("w1c", NID_OFS_IRQ_STATUS, 32'h0000000b);
        check("irq_off", {31'h0, irq}, 32'h0);
        $display("test irq done");
    endtask

    // ----------------------------------------------------------------
    // Clock, reset and main sequence
    // ----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    initial begin
        fail_count = 0;
        checks = 0;
        hresetn = 1'b0;
        {hsel, hwrite, hw_bus_index_load} = 3'h0;
        haddr = 12'h000;
        htrans = 2'b00;
        hsize = 3'b010;
        hwdata = 32'h0;
        hw_bus_index = 10'h000;
        stall = 4'h0;
        st = '0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_node();
        t_phy();
        t_irq();
        results();
    end
endmodule
`default_nettype wire
